// ==== common/ppd_lane_if.sv ====
// Purpose: PIPE-style per-lane data signals between link logic and PHY
// Assumes: every signal is synchronous to the common clock
// Notes:   rate is driven by the link-logic end and read by the PHY end
`timescale 1ns/1ps
interface ppd_lane_if;
	logic [63:0]       txdata;          // transmit word
	logic [1:0]        txdatak;         // transmit control flags
	logic              txdata_valid;    // transmit word qualifier
	logic              txstart_block;   // transmit block begin
	logic [1:0]        txsync_header;   // transmit sync header
	logic [63:0]       rxdata;          // receive word
	logic [1:0]        rxdatak;         // receive control flags
	logic              rxdata_valid;    // receive word qualifier
	logic [1:0]        rxstart_block;   // receive block-begin code
	logic [1:0]        rxsync_header;   // receive sync header
	ppd_pkg::ppd_rate_t rate;           // current link rate

	modport phy (
		input  txdata, txdatak, txdata_valid, txstart_block, txsync_header, rate,
		output rxdata, rxdatak, rxdata_valid, rxstart_block, rxsync_header
	);

	modport mac (
		output txdata, txdatak, txdata_valid, txstart_block, txsync_header, rate,
		input  rxdata, rxdatak, rxdata_valid, rxstart_block, rxsync_header
	);
endinterface : ppd_lane_if

// ==== common/ppd_pkg.sv ====
// Purpose: shared constants, types and helpers of the per-lane PIPE data path
// Assumes: one lane, one clock; rate code 0..3 stands for Gen1..Gen4
// Notes:   serial framing is LSB first, a 2-bit prefix ahead of each Gen1/Gen2 word and each block-start word
package ppd_pkg;

	// word geometry
	localparam int             DATA_W      = 64;         // widest transmit / receive word
	localparam int             HALF_W      = 32;         // narrow variant word, Gen3 word
	localparam int             LOW_W       = 16;         // word used at Gen1 / Gen2
	localparam int             FLAG_W      = 2;          // control-flag and sync-header width
	localparam int             PREFIX_BITS = 2;          // serial prefix ahead of a framed word
	localparam int             BLOCK_BITS  = 128;        // payload bits of one block
	localparam int             SHIFT_W     = DATA_W + PREFIX_BITS;

	// receive block-begin codes
	localparam logic [1:0]     RXSTART_NONE = 2'h0;      // no block start
	localparam logic [1:0]     RXSTART_LO   = 2'h1;      // block starts in lower half
	localparam logic [1:0]     RXSTART_HI   = 2'h2;      // block starts in upper half

	// interface clock figures
	localparam int             SYS_CLK_MHZ   = 200;      // simulation clock rate
	localparam logic [8:0]     PCLK_GEN1_MHZ = 9'h07D;   // 125 MHz at Gen1
	localparam logic [8:0]     PCLK_FAST_MHZ = 9'h0FA;   // 250 MHz at Gen2 and above

	// link rates
	typedef enum logic [1:0] {
		PPD_GEN1,
		PPD_GEN2,
		PPD_GEN3,
		PPD_GEN4
	} ppd_rate_t;

	// narrow variant has no Gen4: fold it onto Gen3
	function automatic ppd_rate_t ppd_eff_rate(input ppd_rate_t r, input logic wide);
		ppd_eff_rate = (!wide && r == PPD_GEN4) ? PPD_GEN3 : r;
	endfunction : ppd_eff_rate

	// true at Gen3 and above
	function automatic logic ppd_is_fast(input ppd_rate_t r);
		ppd_is_fast = (r == PPD_GEN3) || (r == PPD_GEN4);
	endfunction : ppd_is_fast

	// payload bits carried per word at a rate
	function automatic logic [6:0] ppd_word_bits(input ppd_rate_t r);
		case (r)
			PPD_GEN4: ppd_word_bits = 7'h40;
			PPD_GEN3: ppd_word_bits = 7'h20;
			default:  ppd_word_bits = 7'h10;
		endcase
	endfunction : ppd_word_bits

	// clear the bits that a rate does not use
	function automatic logic [63:0] ppd_mask_word(input logic [63:0] d, input ppd_rate_t r);
		case (r)
			PPD_GEN4: ppd_mask_word = d;
			PPD_GEN3: ppd_mask_word = {32'h0, d[31:0]};
			default:  ppd_mask_word = {48'h0, d[15:0]};
		endcase
	endfunction : ppd_mask_word

endpackage : ppd_pkg

// ==== dv/pipe_lane_data_path_bench.sv ====
// Purpose: loop-back bench: link logic to PHY, serial legs back into the PHY
// Assumes: both ends built as the wide variant
// Notes:   each taken word is noted in a queue and checked when it returns
`timescale 1ns/1ps
`define PPD_CHK(act, exp) \
	begin \
		cmp_count++; \
		if ((act) !== (exp)) begin \
			error_cnt++; \
			$display("MISMATCH at %0t: got %h expected %h", $time, (act), (exp)); \
		end \
	end
module pipe_lane_data_path_bench;
	typedef struct packed {
		logic [63:0] d;
		logic [1:0]  k;
		logic        s;
		logic [1:0]  h;
	} ppd_exp_t;

	logic        sys_clk_i = 1'h0;
	logic        resetn_i  = 1'h0;
	logic [1:0]  user_rate = 2'h0;
	logic [63:0] tx_data   = 64'h1;
	logic [1:0]  tx_k      = 2'h1;
	logic [1:0]  tx_sync   = 2'h2;
	logic        tx_req    = 1'h0;
	logic        tx_ready, tx_block, rx_valid, rx_start, ser_p, ser_n;
	logic [63:0] rx_data;
	logic [1:0]  rx_k, rx_sync, gen, cur_sync;
	logic [8:0]  pclk_mhz;
	logic [7:0]  seq = 8'h01;
	logic [17:0] prev_lo = 18'h0;
	ppd_exp_t    exp_q[$];
	int          error_cnt, cmp_count, left, idx, bits, cyc;

	always #2.5 sys_clk_i = ~sys_clk_i;

	ppd_lane_if lane ();
	ppd_mac_lane #(.WIDE(1'h1)) ppd_mac_lane_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .pipe(lane),
		.user_rate_i(user_rate), .user_tx_data_i(tx_data), .user_tx_k_i(tx_k), .user_tx_sync_i(tx_sync),
		.user_tx_req_i(tx_req), .user_tx_ready_o(tx_ready), .user_tx_block_o(tx_block),
		.user_rx_data_o(rx_data), .user_rx_k_o(rx_k), .user_rx_valid_o(rx_valid),
		.user_rx_start_o(rx_start), .user_rx_sync_o(rx_sync));
	ppd_phy_lane #(.WIDE(1'h1)) ppd_phy_lane_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .pipe(lane),
		.tx_p_o(ser_p), .tx_n_o(ser_n), .rx_p_i(ser_p), .rx_n_i(ser_n), .pclk_mhz_o(pclk_mhz));
	ppd_lane_props ppd_lane_props_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .txdata(lane.txdata),
		.txdatak(lane.txdatak), .txdata_valid(lane.txdata_valid), .txstart_block(lane.txstart_block),
		.txsync_header(lane.txsync_header), .rxdatak(lane.rxdatak), .rxdata_valid(lane.rxdata_valid),
		.rxstart_block(lane.rxstart_block), .rxsync_header(lane.rxsync_header), .rate(lane.rate),
		.user_tx_ready_o(tx_ready), .tx_p_o(ser_p), .tx_n_o(ser_n), .pclk_mhz_o(pclk_mhz));

	// payload bits that survive at each rate
	function automatic logic [63:0] ppd_keep_bits(input logic [63:0] d, input logic [1:0] g);
		if (g == 2'h3)
			return d;
		if (g == 2'h2)
			return {32'h0, d[31:0]};
		return {48'h0, d[15:0]};
	endfunction : ppd_keep_bits

	// offer words with random gaps at fast rates, note each taken word
	always @(posedge sys_clk_i) begin
		logic        st;
		logic [63:0] w;
		if (ser_p !== ser_n)
			bits++;
		if (resetn_i && tx_req && tx_ready) begin
			st = (gen >= 2'h2) && ((idx % ((gen == 2'h2) ? 4 : 2)) == 0);
			if (st)
				cur_sync = tx_sync;
			if (idx == 0)
				bits = 0;
			`PPD_CHK(tx_block, st)
			exp_q.push_back({ppd_keep_bits(tx_data, gen), (gen < 2'h2) ? tx_k : 2'h0, st,
				(gen >= 2'h2) ? cur_sync : 2'h0});
			idx++;
			left--;
			seq++;
			w = {$urandom(), $urandom()};
			tx_data <= {w[63:8], seq};
			tx_k <= 2'($urandom());
			tx_sync <= 2'($urandom());
			tx_req <= (left > 0) && ((gen < 2'h2) || ($urandom_range(3) != 0));
		end else if (resetn_i && !tx_req && left > 0)
			tx_req <= 1'($urandom_range(1));
	end

	// take the oldest note whenever a new word is delivered
	always @(posedge sys_clk_i) begin
		ppd_exp_t got;
		ppd_exp_t want;
		got = {rx_data, rx_k, rx_start, rx_sync};
		if (resetn_i && ((gen >= 2'h2) ? (rx_valid === 1'h1) : ({rx_data[15:0], rx_k} !== prev_lo))) begin
			if (exp_q.size() > 0) begin
				want = exp_q.pop_front();
				`PPD_CHK(got, want)
			end else if (gen >= 2'h2) begin
				error_cnt++;
				$display("MISMATCH at %0t: got %h expected %h", $time, got, 69'h0);
			end
		end
		prev_lo = {rx_data[15:0], rx_k};
	end

	// one run at one rate, entered by reset or by a change while idle
	task automatic run_rate(input logic [1:0] r, input int n, input logic rst);
		int t;
		@(posedge sys_clk_i);
		user_rate <= r;
		gen <= r;
		idx <= 0;
		if (rst) begin
			resetn_i <= 1'h0;
			tx_req <= (r < 2'h2);
			tx_data[7:0] <= 8'h01;
			seq <= 8'h01;
			left <= n;
			repeat (10) @(posedge sys_clk_i);
			resetn_i <= 1'h1;
		end else begin
			repeat (2) @(posedge sys_clk_i);
			left <= n;
		end
		@(posedge sys_clk_i);
		t = 0;
		while ((left != 0 || exp_q.size() != 0) && t < 8000) begin
			@(posedge sys_clk_i);
			t++;
		end
		// a run that never drains counts against the verdict
		if (t >= 8000) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, exp_q.size(), 0);
			exp_q.delete();
		end
		if (r >= 2'h2)
			`PPD_CHK(bits, (r == 2'h2) ? n * 32 + 2 * ((n + 3) / 4) : n * 64 + 2 * ((n + 1) / 2))
		`PPD_CHK(pclk_mhz, (r == 2'h0) ? 9'h07D : 9'h0FA)
	endtask : run_rate

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// cut a hang short
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// main sequence: Gen1, Gen2, Gen3 after reset, then Gen4 by an idle change
	initial begin
		int s;
		s = $urandom(93);
		run_rate(2'h0, 24, 1'h1);
		run_rate(2'h1, 24, 1'h1);
		run_rate(2'h2, 40, 1'h1);
		run_rate(2'h3, 30, 1'h0);
		report_and_stop();
	end
endmodule : pipe_lane_data_path_bench

// ==== dv/ppd_lane_props.sv ====
// Purpose: concurrent checks on the lane wires between link logic and PHY
// Assumes: both ends share one clock and one active-low reset
// Notes:   watches the interface, the serial legs and the PHY rate status
`timescale 1ns/1ps
module ppd_lane_props (
	input  wire logic               sys_clk_i,        // lane clock
	input  wire logic               resetn_i,         // async reset, active low
	input  wire logic [63:0]        txdata,           // transmit word
	input  wire logic [1:0]         txdatak,          // transmit flags
	input  wire logic               txdata_valid,     // transmit qualifier
	input  wire logic               txstart_block,    // transmit block begin
	input  wire logic [1:0]         txsync_header,    // transmit sync header
	input  wire logic [1:0]         rxdatak,          // receive flags
	input  wire logic               rxdata_valid,     // receive qualifier
	input  wire logic [1:0]         rxstart_block,    // receive block-begin code
	input  wire logic [1:0]         rxsync_header,    // receive sync header
	input  wire ppd_pkg::ppd_rate_t rate,             // link rate
	input  wire logic               user_tx_ready_o,  // link logic may take a word
	input  wire logic               tx_p_o,           // serial true leg
	input  wire logic               tx_n_o,           // serial complement leg
	input  wire logic [8:0]         pclk_mhz_o        // interface clock status
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// transmit framing seen on the legs
	a_slow_prefix_order: assert property (
		rate <= ppd_pkg::PPD_GEN2 && user_tx_ready_o |-> ##2 (tx_p_o != tx_n_o && tx_p_o == $past(txdatak[0], 2))
		##1 (tx_p_o == $past(txdatak[1], 3)) ##1 (tx_p_o == $past(txdata[0], 4)))
		else $error("slow frame bits out of order");
	a_block_sync_first: assert property (
		rate >= ppd_pkg::PPD_GEN3 && txdata_valid && txstart_block && user_tx_ready_o |-> ##2
		(tx_p_o != tx_n_o && tx_p_o == $past(txsync_header[0], 2)) ##1 (tx_p_o == $past(txsync_header[1], 3))
		##1 (tx_p_o == $past(txdata[0], 4)))
		else $error("block header not sent first");
	a_plain_word_first: assert property (
		rate >= ppd_pkg::PPD_GEN3 && txdata_valid && !txstart_block && user_tx_ready_o |-> ##2
		(tx_p_o != tx_n_o && tx_p_o == $past(txdata[0], 2)))
		else $error("plain word not sent at once");
	a_gen3_top_bit: assert property (
		rate == ppd_pkg::PPD_GEN3 && txdata_valid && txstart_block && user_tx_ready_o |-> ##35
		(tx_p_o != tx_n_o && tx_p_o == $past(txdata[31], 35)) ##1 (!tx_p_o && !tx_n_o))
		else $error("gen3 frame length wrong");
	a_gen4_top_bit: assert property (
		rate == ppd_pkg::PPD_GEN4 && txdata_valid && txstart_block && user_tx_ready_o |-> ##67
		(tx_p_o != tx_n_o && tx_p_o == $past(txdata[63], 67)) ##1 (!tx_p_o && !tx_n_o))
		else $error("gen4 frame length wrong");

	// receive indications
	a_slow_rx_idle: assert property (
		rate <= ppd_pkg::PPD_GEN2 && $past(rate) <= ppd_pkg::PPD_GEN2 && $past(resetn_i) |->
		rxdata_valid && rxstart_block == 2'h0 && rxsync_header == 2'h0)
		else $error("slow rate receive side not idle");
	a_fast_no_flags: assert property (
		rate >= ppd_pkg::PPD_GEN3 && $past(rate) >= ppd_pkg::PPD_GEN3 |-> rxdatak == 2'h0)
		else $error("receive flags set at fast rate");
	a_start_code_legal: assert property (
		rxstart_block != 2'h0 |-> rxdata_valid && rxstart_block != 2'h3
		&& (rate != ppd_pkg::PPD_GEN3 || rxstart_block != 2'h2))
		else $error("illegal block-begin code");
	a_rx_valid_pulse: assert property (
		rate >= ppd_pkg::PPD_GEN3 && $past(rate) >= ppd_pkg::PPD_GEN3 && rxdata_valid |=> !rxdata_valid)
		else $error("receive qualifier longer than one cycle");
	a_sync_holds: assert property (
		rate >= ppd_pkg::PPD_GEN3 && $past(rate) >= ppd_pkg::PPD_GEN3 && rxstart_block == 2'h0 |->
		$stable(rxsync_header))
		else $error("sync header moved inside a block");
	a_pclk_rate: assert property (
		$past(resetn_i) |-> pclk_mhz_o == (($past(rate) == ppd_pkg::PPD_GEN1) ?
		ppd_pkg::PCLK_GEN1_MHZ : ppd_pkg::PCLK_FAST_MHZ))
		else $error("interface clock rate wrong");
endmodule : ppd_lane_props

// ==== rtl/ppd_mac_lane.sv ====
// Purpose: link-logic end of one lane: paces transmit words to the PHY,
//          marks block starts, and filters receive words for the user
// Assumes: the PHY end frames each word as payload bits, with a prefix at Gen1/Gen2 and at block starts
// Notes:   pacing mirrors the PHY serialiser so no word is ever lost
`timescale 1ns/1ps
module ppd_mac_lane #(
	parameter bit WIDE = 1'b1                   // 1: 64-bit Gen4 path, 0: 32-bit Gen3 path
) (
	input  wire logic       sys_clk_i,          // lane clock
	input  wire logic       resetn_i,           // async reset, active low
	ppd_lane_if.mac         pipe,               // PIPE data signals
	input  wire logic [1:0] user_rate_i,        // requested rate, 0..3 = Gen1..Gen4
	input  wire logic [63:0] user_tx_data_i,    // word to send
	input  wire logic [1:0] user_tx_k_i,        // control flags, Gen1/Gen2
	input  wire logic [1:0] user_tx_sync_i,     // sync header of a new block
	input  wire logic       user_tx_req_i,      // word offered
	output logic            user_tx_ready_o,    // word taken when req and ready
	output logic            user_tx_block_o,    // next taken word opens a block
	output logic [63:0]     user_rx_data_o,     // received word
	output logic [1:0]      user_rx_k_o,        // received control flags
	output logic            user_rx_valid_o,    // received word usable
	output logic            user_rx_start_o,    // received word opens a block
	output logic [1:0]      user_rx_sync_o      // sync header of current block
);

	ppd_pkg::ppd_rate_t     rate;
	logic                   fast;
	logic [6:0]             wbits;
	logic                   issue;
	logic [6:0]             pace_reg;
	logic [6:0]             pace_next;
	logic [7:0]             blk_reg;
	logic [7:0]             blk_next;
	logic [63:0]            rx_data_reg;
	logic [1:0]             rx_k_reg;
	logic                   rx_valid_reg;
	logic                   rx_start_reg;
	logic [1:0]             rx_sync_reg;
	logic                   rx_use;

	// transmit pacing and block position
	always_comb begin
		rate            = ppd_pkg::ppd_eff_rate(ppd_pkg::ppd_rate_t'(user_rate_i), WIDE);
		fast            = ppd_pkg::ppd_is_fast(rate);
		wbits           = ppd_pkg::ppd_word_bits(rate);
		user_tx_ready_o = (pace_reg == 7'h00);
		user_tx_block_o = fast && (blk_reg == 8'h00);
		issue           = user_tx_ready_o && (user_tx_req_i || !fast);
		pace_next       = (pace_reg != 7'h00) ? pace_reg - 7'h01 : 7'h00;
		blk_next        = blk_reg;
		if (issue) begin
			pace_next = wbits;
			if (!fast || user_tx_block_o) begin
				pace_next = wbits + 7'(ppd_pkg::PREFIX_BITS);
			end
			if (fast) begin
				blk_next = (blk_reg + {1'b0, wbits} == 8'(ppd_pkg::BLOCK_BITS)) ? 8'h00 : blk_reg + {1'b0, wbits};
			end
		end
	end

	// transmit PIPE group, idle word at Gen1/Gen2 when nothing is offered
	assign pipe.rate          = ppd_pkg::ppd_rate_t'(user_rate_i);   // no reset lag: no stale-rate frame after release
	assign pipe.txdata        = (issue && user_tx_req_i) ? user_tx_data_i : 64'h0;
	assign pipe.txdatak       = (issue && user_tx_req_i && !fast) ? user_tx_k_i : 2'h0;
	assign pipe.txdata_valid  = issue && fast;
	assign pipe.txstart_block = issue && user_tx_block_o;
	assign pipe.txsync_header = (issue && user_tx_block_o) ? user_tx_sync_i : 2'h0;

	// receive filtering
	assign rx_use = !fast || pipe.rxdata_valid;

	// pacing and receive registers
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pace_reg     <= 7'h00;
			blk_reg      <= 8'h00;
			rx_data_reg  <= 64'h0;
			rx_k_reg     <= 2'h0;
			rx_valid_reg <= 1'b0;
			rx_start_reg <= 1'b0;
			rx_sync_reg  <= 2'h0;
		end else begin
			pace_reg     <= pace_next;
			blk_reg      <= blk_next;
			rx_valid_reg <= rx_use;
			rx_start_reg <= rx_use && fast && (pipe.rxstart_block != ppd_pkg::RXSTART_NONE);
			if (rx_use) begin
				rx_data_reg <= ppd_pkg::ppd_mask_word(pipe.rxdata, rate);
				rx_k_reg    <= fast ? 2'h0 : pipe.rxdatak;
			end
			if (rx_use && fast && pipe.rxstart_block != ppd_pkg::RXSTART_NONE) begin
				rx_sync_reg <= pipe.rxsync_header;
			end
		end
	end

	assign user_rx_data_o  = rx_data_reg;
	assign user_rx_k_o     = rx_k_reg;
	assign user_rx_valid_o = rx_valid_reg;
	assign user_rx_start_o = rx_start_reg;
	assign user_rx_sync_o  = rx_sync_reg;

endmodule : ppd_mac_lane

// ==== rtl/ppd_phy_lane.sv ====
// Purpose: PHY end of one lane: takes PIPE transmit words, serialises them,
//          deserialises the receive pair and returns PIPE receive words
// Assumes: link logic paces words to the serial length of each frame
// Notes:   line idles with both legs low; a bit counts only when legs differ
//
// Operation
// - wide upper half used only at Gen4
// - wide bits 31:16 ignored at Gen1/Gen2
// - narrow bits 31:16 used only at Gen3
// - link logic ignores unused receive bits
// - transmit flags mark data or control
// - receive flags mark data or control
// - transmit word taken only when qualified at Gen3/Gen4
// - receive qualifier low means discard word
// - link logic flags first word of block
// - receive block-begin code 00/01, 10 never driven
// - receive sync header given at block start
// - narrow variant qualifiers apply at Gen3
// - per-lane words serialised on own pairs
// - interface clock 125 or 250 MHz
`timescale 1ns/1ps
module ppd_phy_lane #(
	parameter bit WIDE = 1'b1                   // 1: 64-bit Gen4 path, 0: 32-bit Gen3 path
) (
	input  wire logic       sys_clk_i,          // lane clock
	input  wire logic       resetn_i,           // async reset, active low
	ppd_lane_if.phy         pipe,               // PIPE data signals
	output logic            tx_p_o,             // transmit pair, true leg
	output logic            tx_n_o,             // transmit pair, complement leg
	input  wire logic       rx_p_i,             // receive pair, true leg
	input  wire logic       rx_n_i,             // receive pair, complement leg
	output logic [8:0]      pclk_mhz_o          // interface clock rate in MHz
);

	typedef enum logic {
		PPD_RX_PREFIX,
		PPD_RX_DATA
	} ppd_rx_state_t;

	ppd_pkg::ppd_rate_t     rate;
	logic                   fast;
	logic [6:0]             wbits;
	logic [63:0]            tx_word;
	logic [1:0]             tx_prefix;
	logic                   tx_has_prefix;
	logic                   tx_take;

	// effective rate seen by this lane
	always_comb begin
		rate  = ppd_pkg::ppd_eff_rate(pipe.rate, WIDE);
		fast  = ppd_pkg::ppd_is_fast(rate);
		wbits = ppd_pkg::ppd_word_bits(rate);
	end

	// ---------------- transmit ----------------
	logic [65:0]            tx_sh_reg;
	logic [65:0]            tx_sh_next;
	logic [6:0]             tx_cnt_reg;
	logic [6:0]             tx_cnt_next;
	logic                   tx_p_reg;
	logic                   tx_p_next;
	logic                   tx_n_reg;
	logic                   tx_n_next;

	// pick what is taken from the transmit word and its side signals
	always_comb begin
		tx_word = ppd_pkg::ppd_mask_word(pipe.txdata, rate);
		if (fast) begin
			tx_take       = (tx_cnt_reg == 7'h00) && pipe.txdata_valid;
			tx_has_prefix = pipe.txstart_block;
			tx_prefix     = pipe.txsync_header;
		end else begin
			tx_take       = (tx_cnt_reg == 7'h00);
			tx_has_prefix = 1'b1;
			tx_prefix     = pipe.txdatak;
		end
	end

	// serialiser: load a frame, then shift it out LSB first
	always_comb begin
		tx_sh_next  = tx_sh_reg;
		tx_cnt_next = tx_cnt_reg;
		if (tx_take) begin
			if (tx_has_prefix) begin
				tx_sh_next  = {tx_word, tx_prefix};
				tx_cnt_next = wbits + 7'(ppd_pkg::PREFIX_BITS);
			end else begin
				tx_sh_next  = {2'h0, tx_word};
				tx_cnt_next = wbits;
			end
		end else if (tx_cnt_reg != 7'h00) begin
			tx_sh_next  = {1'b0, tx_sh_reg[65:1]};
			tx_cnt_next = tx_cnt_reg - 7'h01;
		end
		// both legs low while idle, else a differential bit
		tx_p_next = (tx_cnt_reg != 7'h00) && tx_sh_reg[0];
		tx_n_next = (tx_cnt_reg != 7'h00) && !tx_sh_reg[0];
	end

	// transmit registers
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_sh_reg  <= 66'h0;
			tx_cnt_reg <= 7'h00;
			tx_p_reg   <= 1'b0;
			tx_n_reg   <= 1'b0;
		end else begin
			tx_sh_reg  <= tx_sh_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_p_reg   <= tx_p_next;
			tx_n_reg   <= tx_n_next;
		end
	end

	assign tx_p_o = tx_p_reg;
	assign tx_n_o = tx_n_reg;

	// ---------------- receive ----------------
	ppd_rx_state_t          rx_st_reg;
	ppd_rx_state_t          rx_st_next;
	logic [1:0]             rx_pre_reg;
	logic [1:0]             rx_pre_next;
	logic [63:0]            rx_acc_reg;
	logic [63:0]            rx_acc_next;
	logic [6:0]             rx_cnt_reg;
	logic [6:0]             rx_cnt_next;
	logic [7:0]             rx_blk_reg;
	logic [7:0]             rx_blk_next;
	logic                   rx_first_reg;
	logic                   rx_first_next;
	logic [63:0]            rxdata_reg;
	logic [63:0]            rxdata_next;
	logic [1:0]             rxdatak_reg;
	logic [1:0]             rxdatak_next;
	logic                   rxvalid_reg;
	logic                   rxvalid_next;
	logic [1:0]             rxstart_reg;
	logic [1:0]             rxstart_next;
	logic [1:0]             rxsync_reg;
	logic [1:0]             rxsync_next;
	logic [8:0]             pclk_reg;
	logic [8:0]             pclk_next;
	logic                   rx_bit_ok;
	logic                   rx_done;
	logic [63:0]            rx_word;
	logic [7:0]             rx_blk_sum;

	// deserialiser and receive word builder
	always_comb begin
		rx_st_next    = rx_st_reg;
		rx_pre_next   = rx_pre_reg;
		rx_acc_next   = rx_acc_reg;
		rx_cnt_next   = rx_cnt_reg;
		rx_blk_next   = rx_blk_reg;
		rx_first_next = rx_first_reg;
		rx_done       = 1'b0;
		rx_bit_ok     = rx_p_i ^ rx_n_i;
		rx_blk_sum    = rx_blk_reg + {1'b0, wbits};
		if (rx_bit_ok) begin
			case (rx_st_reg)
				PPD_RX_PREFIX: begin
					rx_pre_next = {rx_p_i, rx_pre_reg[1]};
					if (rx_cnt_reg == 7'h01) begin
						rx_st_next    = PPD_RX_DATA;
						rx_cnt_next   = 7'h00;
						rx_blk_next   = 8'h00;
						rx_first_next = 1'b1;
					end else begin
						rx_cnt_next = rx_cnt_reg + 7'h01;
					end
				end
				PPD_RX_DATA: begin
					rx_acc_next = {rx_p_i, rx_acc_reg[63:1]};
					if (rx_cnt_reg == wbits - 7'h01) begin
						rx_done       = 1'b1;
						rx_cnt_next   = 7'h00;
						rx_blk_next   = rx_blk_sum;
						rx_first_next = 1'b0;
						if (!fast || rx_blk_sum == 8'(ppd_pkg::BLOCK_BITS)) begin
							rx_st_next = PPD_RX_PREFIX;
						end
					end else begin
						rx_cnt_next = rx_cnt_reg + 7'h01;
					end
				end
				default: begin
					rx_st_next  = PPD_RX_PREFIX;
					rx_cnt_next = 7'h00;
				end
			endcase
		end
		// right-align the finished word
		case (rate)
			ppd_pkg::PPD_GEN4: rx_word = rx_acc_next;
			ppd_pkg::PPD_GEN3: rx_word = {32'h0, rx_acc_next[63:32]};
			default:           rx_word = {48'h0, rx_acc_next[63:48]};
		endcase
	end

	// PIPE receive outputs
	always_comb begin
		rxdata_next  = rx_done ? ppd_pkg::ppd_mask_word(rx_word, rate) : rxdata_reg;
		rxdatak_next = rxdatak_reg;
		rxsync_next  = rxsync_reg;
		rxstart_next = ppd_pkg::RXSTART_NONE;
		if (fast) begin
			rxdatak_next = 2'h0;
			rxvalid_next = rx_done;
			if (rx_done && rx_first_reg) begin
				rxstart_next = ppd_pkg::RXSTART_LO;
				rxsync_next  = rx_pre_reg;
			end
		end else begin
			rxvalid_next = 1'b1;
			rxsync_next  = 2'h0;
			if (rx_done) begin
				rxdatak_next = rx_pre_reg;
			end
		end
		pclk_next = (rate == ppd_pkg::PPD_GEN1) ? ppd_pkg::PCLK_GEN1_MHZ : ppd_pkg::PCLK_FAST_MHZ;
	end

	// receive registers
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_st_reg    <= PPD_RX_PREFIX;
			rx_pre_reg   <= 2'h0;
			rx_acc_reg   <= 64'h0;
			rx_cnt_reg   <= 7'h00;
			rx_blk_reg   <= 8'h00;
			rx_first_reg <= 1'b0;
			rxdata_reg   <= 64'h0;
			rxdatak_reg  <= 2'h0;
			rxvalid_reg  <= 1'b0;
			rxstart_reg  <= 2'h0;
			rxsync_reg   <= 2'h0;
			pclk_reg     <= ppd_pkg::PCLK_GEN1_MHZ;
		end else begin
			rx_st_reg    <= rx_st_next;
			rx_pre_reg   <= rx_pre_next;
			rx_acc_reg   <= rx_acc_next;
			rx_cnt_reg   <= rx_cnt_next;
			rx_blk_reg   <= rx_blk_next;
			rx_first_reg <= rx_first_next;
			rxdata_reg   <= rxdata_next;
			rxdatak_reg  <= rxdatak_next;
			rxvalid_reg  <= rxvalid_next;
			rxstart_reg  <= rxstart_next;
			rxsync_reg   <= rxsync_next;
			pclk_reg     <= pclk_next;
		end
	end

	// drive the PIPE receive group and status
	assign pipe.rxdata        = rxdata_reg;
	assign pipe.rxdatak       = rxdatak_reg;
	assign pipe.rxdata_valid  = rxvalid_reg;
	assign pipe.rxstart_block = rxstart_reg;
	assign pipe.rxsync_header = rxsync_reg;
	assign pclk_mhz_o         = pclk_reg;

endmodule : ppd_phy_lane
